//--- rtl/resi_pkg.sv
// Purpose: Constants and types for the radio event, shortcut and interrupt-enable register bank.
// Assumes: APB slave with 32-bit data; byte offsets below are the register addresses.
// Notes: Event, task and shortcut tables are indexed by the constants declared here.
package resi_pkg;

	localparam int RESI_ADDR_W = 12;
	localparam int RESI_NUM_EV = 15;
	localparam int RESI_NUM_TASK = 9;
	localparam int RESI_NUM_SC = 12;

	// Event indices into the event vector.
	localparam int RESI_EV_READY = 0;
	localparam int RESI_EV_ADDRESS = 1;
	localparam int RESI_EV_PAYLOAD = 2;
	localparam int RESI_EV_END = 3;
	localparam int RESI_EV_DISABLED = 4;
	localparam int RESI_EV_ADDRMATCH = 5;
	localparam int RESI_EV_ADDRMISS = 6;
	localparam int RESI_EV_SSDONE = 7;
	localparam int RESI_EV_BCCMP = 8;
	localparam int RESI_EV_CKGOOD = 9;
	localparam int RESI_EV_CKBAD = 10;
	localparam int RESI_EV_TXRDY = 11;
	localparam int RESI_EV_RXRDY = 12;
	localparam int RESI_EV_HDRMATCH = 13;
	localparam int RESI_EV_PHYEND = 14;

	// Task indices into the task pulse vector.
	localparam int RESI_TK_TXGO = 0;
	localparam int RESI_TK_RXGO = 1;
	localparam int RESI_TK_START = 2;
	localparam int RESI_TK_STOP = 3;
	localparam int RESI_TK_DISABLE = 4;
	localparam int RESI_TK_SSBEGIN = 5;
	localparam int RESI_TK_SSHALT = 6;
	localparam int RESI_TK_BCBEGIN = 7;
	localparam int RESI_TK_BCHALT = 8;

	// Register offsets.
	localparam logic [11:0] RESI_EV_OFF [RESI_NUM_EV] = '{12'h100, 12'h104, 12'h108, 12'h10c, 12'h110,
		12'h114, 12'h118, 12'h11c, 12'h128, 12'h130, 12'h134, 12'h154, 12'h158, 12'h15c, 12'h16c};
	localparam logic [11:0] RESI_TASK_OFF [RESI_NUM_TASK] = '{12'h000, 12'h004, 12'h008, 12'h00c,
		12'h010, 12'h014, 12'h018, 12'h01c, 12'h020};
	localparam logic [11:0] RESI_LINKS_OFF = 12'h200;
	localparam logic [11:0] RESI_IEN_SET_OFF = 12'h304;
	localparam logic [11:0] RESI_IEN_CLR_OFF = 12'h308;

	// Field layouts.
	localparam int RESI_IRQ_BIT [RESI_NUM_EV] = '{0, 1, 2, 3, 4, 5, 6, 7, 10, 12, 13, 21, 22, 23, 27};
	localparam int RESI_SC_BIT [RESI_NUM_SC] = '{0, 1, 2, 3, 4, 5, 6, 7, 20, 21, 22, 23};
	localparam int RESI_SC_EV [RESI_NUM_SC] = '{RESI_EV_READY, RESI_EV_END, RESI_EV_DISABLED,
		RESI_EV_DISABLED, RESI_EV_ADDRESS, RESI_EV_END, RESI_EV_ADDRESS, RESI_EV_DISABLED,
		RESI_EV_TXRDY, RESI_EV_RXRDY, RESI_EV_PHYEND, RESI_EV_PHYEND};
	localparam int RESI_SC_TASK [RESI_NUM_SC] = '{RESI_TK_START, RESI_TK_DISABLE, RESI_TK_TXGO,
		RESI_TK_RXGO, RESI_TK_SSBEGIN, RESI_TK_START, RESI_TK_BCBEGIN, RESI_TK_SSHALT,
		RESI_TK_START, RESI_TK_START, RESI_TK_DISABLE, RESI_TK_START};
	localparam logic [31:0] RESI_LINKS_MASK = 32'h00f0_00ff;
	localparam logic [31:0] RESI_IEN_MASK = 32'h08e0_34ff;

	// Reset values.
	localparam logic [RESI_NUM_EV-1:0] RESI_EV_RST = 15'h0000;
	localparam logic [31:0] RESI_LINKS_RST = 32'h0000_0000;
	localparam logic [31:0] RESI_IEN_RST = 32'h0000_0000;

	typedef struct packed {
		logic [RESI_NUM_EV-1:0] ev;
		logic [31:0] links;
		logic [31:0] ien;
		logic [RESI_NUM_TASK-1:0] tsk;
		logic irq;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} resi_state_t;

	localparam resi_state_t RESI_STATE_RST = '{ev: RESI_EV_RST, links: RESI_LINKS_RST, ien: RESI_IEN_RST,
		tsk: '0, irq: 1'b0, prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0};

endpackage : resi_pkg

//--- rtl/resi_regs.sv
// Purpose: Event flags, event-to-task shortcuts and interrupt enables of a packet transceiver, on APB.
// Assumes: EVENT_I bits are one-cycle pulses from the transceiver core, synchronous to CLK_I.
// Notes: Reads answer with zero wait states; an unmapped address answers with PSLVERR.
`timescale 1ns/1ps
module resi_regs
	import resi_pkg::*;
(
	input wire logic CLK_I,
	input wire logic RESET_N_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [RESI_ADDR_W-1:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	input wire logic [RESI_NUM_EV-1:0] EVENT_I,
	output logic [RESI_NUM_TASK-1:0] TASK_O,
	output logic IRQ_O
);

	resi_state_t s_r;
	resi_state_t s_nxt;
	logic setup;
	logic wr_acc;
	logic hit;
	logic [31:0] rd;
	logic [31:0] ien_rd;

	assign setup = PSEL_I && !PENABLE_I;
	assign wr_acc = PSEL_I && PENABLE_I && s_r.pready && PWRITE_I;

	always_comb begin
		hit = 1'b0;
		rd = 32'h0000_0000;
		ien_rd = s_r.ien & RESI_IEN_MASK;
		for (int i = 0; i < RESI_NUM_EV; i++) begin
			if (PADDR_I == RESI_EV_OFF[i]) begin
				hit = 1'b1;
				rd = {31'h0000_0000, s_r.ev[i]};
			end
		end
		for (int t = 0; t < RESI_NUM_TASK; t++) begin
			if (PADDR_I == RESI_TASK_OFF[t]) begin
				hit = 1'b1;
			end
		end
		if (PADDR_I == RESI_LINKS_OFF) begin
			hit = 1'b1;
			rd = s_r.links;
		end
		if (PADDR_I == RESI_IEN_SET_OFF || PADDR_I == RESI_IEN_CLR_OFF) begin
			hit = 1'b1;
			rd = ien_rd;
		end
	end

	always_comb begin
		s_nxt = s_r;
		s_nxt.pready = setup;
		s_nxt.pslverr = setup && !hit;
		s_nxt.tsk = '0;
		if (setup && !PWRITE_I && hit) begin
			s_nxt.prdata = rd;
		end else if (setup) begin
			s_nxt.prdata = 32'h0000_0000;
		end
		for (int i = 0; i < RESI_NUM_EV; i++) begin
			if (wr_acc && PADDR_I == RESI_EV_OFF[i]) begin
				s_nxt.ev[i] = PWDATA_I[0];
			end
			if (EVENT_I[i]) begin
				s_nxt.ev[i] = 1'b1;
			end
		end
		for (int t = 0; t < RESI_NUM_TASK; t++) begin
			if (wr_acc && PADDR_I == RESI_TASK_OFF[t] && PWDATA_I[0]) begin
				s_nxt.tsk[t] = 1'b1;
			end
		end
		for (int k = 0; k < RESI_NUM_SC; k++) begin
			if (s_r.links[RESI_SC_BIT[k]] && EVENT_I[RESI_SC_EV[k]]) begin
				s_nxt.tsk[RESI_SC_TASK[k]] = 1'b1;
			end
		end
		if (wr_acc && PADDR_I == RESI_LINKS_OFF) begin
			s_nxt.links = PWDATA_I & RESI_LINKS_MASK;
		end
		if (wr_acc && PADDR_I == RESI_IEN_SET_OFF) begin
			s_nxt.ien = s_r.ien | (PWDATA_I & RESI_IEN_MASK);
		end
		if (wr_acc && PADDR_I == RESI_IEN_CLR_OFF) begin
			s_nxt.ien = s_r.ien & ~(PWDATA_I & RESI_IEN_MASK);
		end
		s_nxt.irq = 1'b0;
		for (int i = 0; i < RESI_NUM_EV; i++) begin
			if (s_r.ev[i] && s_r.ien[RESI_IRQ_BIT[i]]) begin
				s_nxt.irq = 1'b1;
			end
		end
	end

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			s_r <= RESI_STATE_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign PRDATA_O = s_r.prdata;
	assign PREADY_O = s_r.pready;
	assign PSLVERR_O = s_r.pslverr;
	assign TASK_O = s_r.tsk;
	assign IRQ_O = s_r.irq;

	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!RESET_N_I);

	addr_match_set_a: assert property (EVENT_I[RESI_EV_ADDRMATCH] |=> s_r.ev[RESI_EV_ADDRMATCH])
		else $error("Address-match flag did not set.");
	addr_miss_set_a: assert property (EVENT_I[RESI_EV_ADDRMISS] |=> s_r.ev[RESI_EV_ADDRMISS])
		else $error("Address-miss flag did not set.");
	ss_done_set_a: assert property (EVENT_I[RESI_EV_SSDONE] |=> s_r.ev[RESI_EV_SSDONE])
		else $error("Signal-strength-done flag did not set.");
	bc_cmp_set_a: assert property (EVENT_I[RESI_EV_BCCMP] |=> s_r.ev[RESI_EV_BCCMP])
		else $error("Bit-count-compare flag did not set.");
	ck_good_set_a: assert property (EVENT_I[RESI_EV_CKGOOD] |=> s_r.ev[RESI_EV_CKGOOD])
		else $error("Checksum-good flag did not set.");
	ck_bad_set_a: assert property (EVENT_I[RESI_EV_CKBAD] |=> s_r.ev[RESI_EV_CKBAD])
		else $error("Checksum-bad flag did not set.");
	tx_ready_set_a: assert property (EVENT_I[RESI_EV_TXRDY] |=> s_r.ev[RESI_EV_TXRDY])
		else $error("Transmit-ready flag did not set.");
	rx_ready_set_a: assert property (EVENT_I[RESI_EV_RXRDY] |=> s_r.ev[RESI_EV_RXRDY])
		else $error("Receive-ready flag did not set.");
	hdr_match_set_a: assert property (EVENT_I[RESI_EV_HDRMATCH] |=> s_r.ev[RESI_EV_HDRMATCH])
		else $error("Header-match flag did not set.");
	phy_end_set_a: assert property (EVENT_I[RESI_EV_PHYEND] |=> s_r.ev[RESI_EV_PHYEND])
		else $error("Physical-end flag did not set.");
	flag_clear_a: assert property ((wr_acc && PADDR_I == RESI_EV_OFF[RESI_EV_ADDRMISS] && !PWDATA_I[0]
		&& !EVENT_I[RESI_EV_ADDRMISS]) |=> !s_r.ev[RESI_EV_ADDRMISS])
		else $error("Event flag did not clear on a zero write.");
	ready_start_a: assert property ((s_r.links[0] && EVENT_I[RESI_EV_READY]) |=> TASK_O[RESI_TK_START])
		else $error("Ready-to-start link did not fire.");
	end_disable_a: assert property ((s_r.links[1] && EVENT_I[RESI_EV_END]) |=> TASK_O[RESI_TK_DISABLE])
		else $error("End-to-disable link did not fire.");
	dis_tx_a: assert property ((s_r.links[2] && EVENT_I[RESI_EV_DISABLED]) |=> TASK_O[RESI_TK_TXGO])
		else $error("Disabled-to-transmit link did not fire.");
	dis_rx_a: assert property ((s_r.links[3] && EVENT_I[RESI_EV_DISABLED]) |=> TASK_O[RESI_TK_RXGO])
		else $error("Disabled-to-receive link did not fire.");
	addr_ss_a: assert property ((s_r.links[4] && EVENT_I[RESI_EV_ADDRESS]) |=> TASK_O[RESI_TK_SSBEGIN])
		else $error("Address-to-sample link did not fire.");
	addr_bc_a: assert property ((s_r.links[6] && EVENT_I[RESI_EV_ADDRESS]) |=> TASK_O[RESI_TK_BCBEGIN])
		else $error("Address-to-counter link did not fire.");
	end_start_a: assert property ((s_r.links[5] && EVENT_I[RESI_EV_END]) |=> TASK_O[RESI_TK_START])
		else $error("End-to-start link did not fire.");
	dis_sshalt_a: assert property ((s_r.links[7] && EVENT_I[RESI_EV_DISABLED]) |=> TASK_O[RESI_TK_SSHALT])
		else $error("Disabled-to-halt link did not fire.");
	rdy_start_a: assert property ((s_r.links[20] && EVENT_I[RESI_EV_TXRDY]) || (s_r.links[21]
		&& EVENT_I[RESI_EV_RXRDY]) |=> TASK_O[RESI_TK_START])
		else $error("Ready-to-start link did not fire.");
	phy_links_a: assert property ((s_r.links[22] && EVENT_I[RESI_EV_PHYEND]) |=> TASK_O[RESI_TK_DISABLE])
		else $error("Physical-end-to-disable link did not fire.");
	phy_start_a: assert property ((s_r.links[23] && EVENT_I[RESI_EV_PHYEND]) |=> TASK_O[RESI_TK_START])
		else $error("Physical-end-to-start link did not fire.");
	no_link_a: assert property ((s_r.links == 32'h0000_0000 && !wr_acc) |=> TASK_O == '0)
		else $error("Task fired with no link and no write.");
	ien_set_a: assert property ((wr_acc && PADDR_I == RESI_IEN_SET_OFF)
		|=> s_r.ien == ($past(s_r.ien) | ($past(PWDATA_I) & RESI_IEN_MASK)))
		else $error("Enable-set write gave the wrong enables.");
	ien_clr_a: assert property ((wr_acc && PADDR_I == RESI_IEN_CLR_OFF)
		|=> s_r.ien == ($past(s_r.ien) & ~($past(PWDATA_I) & RESI_IEN_MASK)))
		else $error("Enable-clear write gave the wrong enables.");
	ien_read_a: assert property ((setup && !PWRITE_I && (PADDR_I == RESI_IEN_SET_OFF
		|| PADDR_I == RESI_IEN_CLR_OFF)) |=> PREADY_O && PRDATA_O == $past(s_r.ien))
		else $error("Enable read did not return the enables.");
	irq_level_a: assert property (IRQ_O == $past(|(s_r.ev & {s_r.ien[27], s_r.ien[23:21], s_r.ien[13:12],
		s_r.ien[10], s_r.ien[7:0]})))
		else $error("Interrupt output does not follow enabled flags.");
	task_write_a: assert property ((wr_acc && PADDR_I == RESI_TASK_OFF[RESI_TK_STOP] && PWDATA_I[0])
		|=> TASK_O[RESI_TK_STOP] ##1 !TASK_O[RESI_TK_STOP])
		else $error("Task write did not give a one-cycle pulse.");
	apb_answer_a: assert property (setup |=> PREADY_O && (PSLVERR_O == !$past(hit)))
		else $error("APB answer missing or wrong error.");

	addr_match_hold_a: assert property ((s_r.ev[RESI_EV_ADDRMATCH] && !(wr_acc && !PWDATA_I[0]
		&& PADDR_I == RESI_EV_OFF[RESI_EV_ADDRMATCH])) |=> s_r.ev[RESI_EV_ADDRMATCH])
		else $error("Address-match flag dropped without a zero write.");

	addr_match_read_a: assert property ((setup && !PWRITE_I && PADDR_I == RESI_EV_OFF[RESI_EV_ADDRMATCH])
		|=> PRDATA_O == 32'($past(s_r.ev[RESI_EV_ADDRMATCH])))
		else $error("Address-match flag read back wrong.");

	addr_match_clr_a: assert property ((wr_acc && !PWDATA_I[0] && !EVENT_I[RESI_EV_ADDRMATCH]
		&& PADDR_I == RESI_EV_OFF[RESI_EV_ADDRMATCH]) |=> !s_r.ev[RESI_EV_ADDRMATCH])
		else $error("Address-match flag did not clear on a zero write.");

	addr_miss_hold_a: assert property ((s_r.ev[RESI_EV_ADDRMISS] && !(wr_acc && !PWDATA_I[0]
		&& PADDR_I == RESI_EV_OFF[RESI_EV_ADDRMISS])) |=> s_r.ev[RESI_EV_ADDRMISS])
		else $error("Address-miss flag dropped without a zero write.");

	addr_miss_read_a: assert property ((setup && !PWRITE_I && PADDR_I == RESI_EV_OFF[RESI_EV_ADDRMISS])
		|=> PRDATA_O == 32'($past(s_r.ev[RESI_EV_ADDRMISS])))
		else $error("Address-miss flag read back wrong.");

	ss_done_hold_a: assert property ((s_r.ev[RESI_EV_SSDONE] && !(wr_acc && !PWDATA_I[0]
		&& PADDR_I == RESI_EV_OFF[RESI_EV_SSDONE])) |=> s_r.ev[RESI_EV_SSDONE])
		else $error("Signal-strength-done flag dropped without a zero write.");

	ss_done_read_a: assert property ((setup && !PWRITE_I && PADDR_I == RESI_EV_OFF[RESI_EV_SSDONE])
		|=> PRDATA_O == 32'($past(s_r.ev[RESI_EV_SSDONE])))
		else $error("Signal-strength-done flag read back wrong.");

	ss_done_clr_a: assert property ((wr_acc && !PWDATA_I[0] && !EVENT_I[RESI_EV_SSDONE]
		&& PADDR_I == RESI_EV_OFF[RESI_EV_SSDONE]) |=> !s_r.ev[RESI_EV_SSDONE])
		else $error("Signal-strength-done flag did not clear on a zero write.");

	bc_cmp_hold_a: assert property ((s_r.ev[RESI_EV_BCCMP] && !(wr_acc && !PWDATA_I[0]
		&& PADDR_I == RESI_EV_OFF[RESI_EV_BCCMP])) |=> s_r.ev[RESI_EV_BCCMP])
		else $error("Bit-count-compare flag dropped without a zero write.");

	bc_cmp_read_a: assert property ((setup && !PWRITE_I && PADDR_I == RESI_EV_OFF[RESI_EV_BCCMP])
		|=> PRDATA_O == 32'($past(s_r.ev[RESI_EV_BCCMP])))
		else $error("Bit-count-compare flag read back wrong.");

	bc_cmp_clr_a: assert property ((wr_acc && !PWDATA_I[0] && !EVENT_I[RESI_EV_BCCMP]
		&& PADDR_I == RESI_EV_OFF[RESI_EV_BCCMP]) |=> !s_r.ev[RESI_EV_BCCMP])
		else $error("Bit-count-compare flag did not clear on a zero write.");

	ck_good_hold_a: assert property ((s_r.ev[RESI_EV_CKGOOD] && !(wr_acc && !PWDATA_I[0]
		&& PADDR_I == RESI_EV_OFF[RESI_EV_CKGOOD])) |=> s_r.ev[RESI_EV_CKGOOD])
		else $error("Checksum-good flag dropped without a zero write.");

	ck_good_read_a: assert property ((setup && !PWRITE_I && PADDR_I == RESI_EV_OFF[RESI_EV_CKGOOD])
		|=> PRDATA_O == 32'($past(s_r.ev[RESI_EV_CKGOOD])))
		else $error("Checksum-good flag read back wrong.");

	ck_good_clr_a: assert property ((wr_acc && !PWDATA_I[0] && !EVENT_I[RESI_EV_CKGOOD]
		&& PADDR_I == RESI_EV_OFF[RESI_EV_CKGOOD]) |=> !s_r.ev[RESI_EV_CKGOOD])
		else $error("Checksum-good flag did not clear on a zero write.");

	ck_bad_hold_a: assert property ((s_r.ev[RESI_EV_CKBAD] && !(wr_acc && !PWDATA_I[0]
		&& PADDR_I == RESI_EV_OFF[RESI_EV_CKBAD])) |=> s_r.ev[RESI_EV_CKBAD])
		else $error("Checksum-bad flag dropped without a zero write.");

	ck_bad_read_a: assert property ((setup && !PWRITE_I && PADDR_I == RESI_EV_OFF[RESI_EV_CKBAD])
		|=> PRDATA_O == 32'($past(s_r.ev[RESI_EV_CKBAD])))
		else $error("Checksum-bad flag read back wrong.");

	ck_bad_clr_a: assert property ((wr_acc && !PWDATA_I[0] && !EVENT_I[RESI_EV_CKBAD]
		&& PADDR_I == RESI_EV_OFF[RESI_EV_CKBAD]) |=> !s_r.ev[RESI_EV_CKBAD])
		else $error("Checksum-bad flag did not clear on a zero write.");

	tx_ready_hold_a: assert property ((s_r.ev[RESI_EV_TXRDY] && !(wr_acc && !PWDATA_I[0]
		&& PADDR_I == RESI_EV_OFF[RESI_EV_TXRDY])) |=> s_r.ev[RESI_EV_TXRDY])
		else $error("Transmit-ready flag dropped without a zero write.");

	tx_ready_read_a: assert property ((setup && !PWRITE_I && PADDR_I == RESI_EV_OFF[RESI_EV_TXRDY])
		|=> PRDATA_O == 32'($past(s_r.ev[RESI_EV_TXRDY])))
		else $error("Transmit-ready flag read back wrong.");

	tx_ready_clr_a: assert property ((wr_acc && !PWDATA_I[0] && !EVENT_I[RESI_EV_TXRDY]
		&& PADDR_I == RESI_EV_OFF[RESI_EV_TXRDY]) |=> !s_r.ev[RESI_EV_TXRDY])
		else $error("Transmit-ready flag did not clear on a zero write.");

	rx_ready_hold_a: assert property ((s_r.ev[RESI_EV_RXRDY] && !(wr_acc && !PWDATA_I[0]
		&& PADDR_I == RESI_EV_OFF[RESI_EV_RXRDY])) |=> s_r.ev[RESI_EV_RXRDY])
		else $error("Receive-ready flag dropped without a zero write.");

	rx_ready_read_a: assert property ((setup && !PWRITE_I && PADDR_I == RESI_EV_OFF[RESI_EV_RXRDY])
		|=> PRDATA_O == 32'($past(s_r.ev[RESI_EV_RXRDY])))
		else $error("Receive-ready flag read back wrong.");

	rx_ready_clr_a: assert property ((wr_acc && !PWDATA_I[0] && !EVENT_I[RESI_EV_RXRDY]
		&& PADDR_I == RESI_EV_OFF[RESI_EV_RXRDY]) |=> !s_r.ev[RESI_EV_RXRDY])
		else $error("Receive-ready flag did not clear on a zero write.");

	hdr_match_hold_a: assert property ((s_r.ev[RESI_EV_HDRMATCH] && !(wr_acc && !PWDATA_I[0]
		&& PADDR_I == RESI_EV_OFF[RESI_EV_HDRMATCH])) |=> s_r.ev[RESI_EV_HDRMATCH])
		else $error("Header-match flag dropped without a zero write.");

	hdr_match_read_a: assert property ((setup && !PWRITE_I && PADDR_I == RESI_EV_OFF[RESI_EV_HDRMATCH])
		|=> PRDATA_O == 32'($past(s_r.ev[RESI_EV_HDRMATCH])))
		else $error("Header-match flag read back wrong.");

	hdr_match_clr_a: assert property ((wr_acc && !PWDATA_I[0] && !EVENT_I[RESI_EV_HDRMATCH]
		&& PADDR_I == RESI_EV_OFF[RESI_EV_HDRMATCH]) |=> !s_r.ev[RESI_EV_HDRMATCH])
		else $error("Header-match flag did not clear on a zero write.");

	phy_end_hold_a: assert property ((s_r.ev[RESI_EV_PHYEND] && !(wr_acc && !PWDATA_I[0]
		&& PADDR_I == RESI_EV_OFF[RESI_EV_PHYEND])) |=> s_r.ev[RESI_EV_PHYEND])
		else $error("Physical-end flag dropped without a zero write.");

	phy_end_read_a: assert property ((setup && !PWRITE_I && PADDR_I == RESI_EV_OFF[RESI_EV_PHYEND])
		|=> PRDATA_O == 32'($past(s_r.ev[RESI_EV_PHYEND])))
		else $error("Physical-end flag read back wrong.");

	phy_end_clr_a: assert property ((wr_acc && !PWDATA_I[0] && !EVENT_I[RESI_EV_PHYEND]
		&& PADDR_I == RESI_EV_OFF[RESI_EV_PHYEND]) |=> !s_r.ev[RESI_EV_PHYEND])
		else $error("Physical-end flag did not clear on a zero write.");

	links_write_a: assert property ((wr_acc && PADDR_I == RESI_LINKS_OFF)
		|=> s_r.links == ($past(PWDATA_I) & RESI_LINKS_MASK))
		else $error("Link write gave the wrong links.");

	links_read_a: assert property ((setup && !PWRITE_I && PADDR_I == RESI_LINKS_OFF)
		|=> PRDATA_O == $past(s_r.links))
		else $error("Link read did not return the links.");

	ien_mask_a: assert property ((s_r.ien & ~RESI_IEN_MASK) == 32'h0000_0000)
		else $error("Unimplemented enable bit is set.");

	task_zero_a: assert property ((wr_acc && PADDR_I == RESI_TASK_OFF[RESI_TK_STOP] && !PWDATA_I[0])
		|=> !TASK_O[RESI_TK_STOP])
		else $error("Zero write to a task register fired the task.");

	ready_pulse_a: assert property (PREADY_O |=> !PREADY_O)
		else $error("Bus ready stood longer than one cycle.");

	err_ready_a: assert property (PSLVERR_O |-> PREADY_O)
		else $error("Bus error came without ready.");

endmodule : resi_regs

//--- tb/resi_core_model.sv
// Purpose: Stand-in for the transceiver core that raises event pulses.
// Assumes: One request gives one event pulse of one cycle.
// Notes: Every event line is low outside a pulse.
`timescale 1ns/1ps
module resi_core_model
	import resi_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic fire_i,
	input wire logic [3:0] idx_i,
	output logic [RESI_NUM_EV-1:0] event_o
);
	// Pulses are launched just after an edge and last one cycle.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			event_o <= '0;
		end else begin
			event_o <= fire_i ? (RESI_NUM_EV'(1) << idx_i) : '0;
		end
	end
endmodule : resi_core_model

//--- tb/testbench.sv
// Purpose: Self-checking bench for the event, link and enable registers.
// Assumes: Zero-wait APB slave; flags, links and enables reset to zero.
// Notes: Task pulses are gathered in a sticky vector between checks.
`timescale 1ns/1ps
module testbench;
	import resi_pkg::*;
	logic clk, rst_n, psel, penable, pwrite, fire, clr, pready, pslverr, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [RESI_NUM_EV-1:0] ev;
	logic [RESI_NUM_TASK-1:0] tsk, seen;
	logic [3:0] idx;
	int n_errors, num_checks;
	resi_regs dut_u (.CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
		.PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
		.EVENT_I(ev), .TASK_O(tsk), .IRQ_O(irq));
	resi_core_model core_u (.clk_i(clk), .rst_n_i(rst_n), .fire_i(fire), .idx_i(idx), .event_o(ev));
	initial begin
		clk = 0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) seen <= clr ? '0 : (seen | tsk);
	task print_verdict;
		$display("Checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : print_verdict
	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		@(posedge clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
		if (pready !== 1'b1) begin
			n_errors++;
			$display("ERROR pready expected 1 seen %b", pready);
			print_verdict();
		end
	endtask : apb
	task wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask : wr
	task rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(nm, exp, r);
	endtask : rd
	task fire_ev(input int i);
		@(posedge clk);
		clr <= 1;
		fire <= 1;
		idx <= 4'(i);
		@(posedge clk);
		clr <= 0;
		fire <= 0;
		repeat (3) @(posedge clk);
	endtask : fire_ev
	task t_reset;
		logic [31:0] r;
		logic e;
		rd("links", RESI_LINKS_OFF, 32'h0);
		rd("ien", RESI_IEN_SET_OFF, 32'h0);
		rd("miss_flag", RESI_EV_OFF[RESI_EV_ADDRMISS], 32'h0);
		apb(1'b0, 12'h7f0, 32'h0, r, e);
		chk("slverr", 32'h1, {31'h0, e});
		wr(RESI_LINKS_OFF, 32'hffff_ffff);
		rd("links_all", RESI_LINKS_OFF, RESI_LINKS_MASK);
		wr(RESI_LINKS_OFF, 32'h0);
		$display("reset test done");
	endtask : t_reset
	task t_events;
		for (int i = RESI_EV_ADDRMATCH; i <= RESI_EV_PHYEND; i++) begin
			fire_ev(i);
			rd("flag_set", RESI_EV_OFF[i], 32'h1);
			wr(RESI_EV_OFF[i], 32'h0);
			rd("flag_clr", RESI_EV_OFF[i], 32'h0);
		end
		$display("event test done");
	endtask : t_events
	task t_irq;
		wr(RESI_IEN_SET_OFF, 32'h0000_1000);
		wr(RESI_IEN_SET_OFF, 32'h0);
		rd("ien_set", RESI_IEN_SET_OFF, 32'h0000_1000);
		chk("irq_idle", 32'h0, {31'h0, irq});
		fire_ev(RESI_EV_CKGOOD);
		chk("irq_on", 32'h1, {31'h0, irq});
		wr(RESI_IEN_CLR_OFF, 32'h0000_1000);
		repeat (2) @(posedge clk);
		chk("irq_off", 32'h0, {31'h0, irq});
		rd("ien_clr", RESI_IEN_CLR_OFF, 32'h0);
		wr(RESI_EV_OFF[RESI_EV_CKGOOD], 32'h0);
		$display("interrupt test done");
	endtask : t_irq
	task t_links;
		fire_ev(RESI_EV_READY);
		chk("no_link", 32'h0, 32'(seen));
		for (int k = 0; k < RESI_NUM_SC; k++) begin
			wr(RESI_LINKS_OFF, 32'h1 << RESI_SC_BIT[k]);
			fire_ev(RESI_SC_EV[k]);
			chk("link_task", 32'h1 << RESI_SC_TASK[k], 32'(seen));
		end
		wr(RESI_LINKS_OFF, 32'h0);
		$display("link test done");
	endtask : t_links
	task t_tasks;
		@(posedge clk);
		clr <= 1;
		@(posedge clk);
		clr <= 0;
		wr(RESI_TASK_OFF[RESI_TK_STOP], 32'h0);
		repeat (3) @(posedge clk);
		chk("task_zero", 32'h0, 32'(seen));
		for (int t = 0; t < RESI_NUM_TASK; t++) begin
			@(posedge clk);
			clr <= 1;
			@(posedge clk);
			clr <= 0;
			wr(RESI_TASK_OFF[t], 32'h1);
			repeat (3) @(posedge clk);
			chk("task_pulse", 32'h1 << t, 32'(seen));
		end
		$display("task test done");
	endtask : t_tasks
	initial begin
		{rst_n, psel, penable, pwrite, fire, clr} = '0;
		paddr = '0;
		pwdata = '0;
		idx = '0;
		n_errors = 0;
		num_checks = 0;
		repeat (20) @(posedge clk);
		rst_n <= 1;
		t_reset();
		t_events();
		t_irq();
		t_links();
		t_tasks();
		print_verdict();
	end
endmodule : testbench
